// file: common/pulse_stop_pkg.sv
// constants, status layout and state codes for the per-axis stop and arc check block
// assumes a single 50 MHz core clock; no import, every use is scoped
package pulse_stop_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;                  // core clock period
	localparam int unsigned PULSE_ACT_NS  = 100;                 // least active (low) pulse width
	localparam int unsigned PULSE_ACT_CYC = (PULSE_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [31:0] RAD_MIN       = 32'h0000_0002;       // least arc radius, 2
	localparam logic [31:0] RAD_MAX       = 32'h2D41_3CCC;       // largest arc radius, 759250124
	localparam logic [7:0]  STRETCH_MUL   = 8'hB5;               // 181/128 approximates 1.414
	localparam int unsigned STRETCH_SHIFT = 7;                   // right shift giving the 128 divisor of the stretch factor
	localparam logic [15:0] DECEL_STEP    = 16'h0001;            // period growth per pulse while slowing
	localparam logic [15:0] PERIOD_RST    = 16'h0010;            // period after reset

	// drive kinds
	typedef enum logic [1:0] {
		KIND_SINGLE = 2'h0,
		KIND_LINEAR = 2'h1,
		KIND_ARC_CENTER = 2'h2,
		KIND_ARC_PASS = 2'h3
	} drive_kind_t;

	// one-hot control states
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_STANDBY_WAIT_BIT   = 6'h02,
		ST_DRIVE  = 6'h04,
		ST_DECEL  = 6'h08,
		ST_FINISH = 6'h10,
		ST_SETTLE = 6'h20
	} ctl_state_t;

	// status port seen by software
	typedef struct packed {
		logic busy;
		logic drive;
		logic standby_wait_bit;
		logic external_pulse_out_bit;
		logic slow_end_flag;
		logic fast_end_flag;
		logic limit_end_flag;
		logic error;
	} status_t;

	// arc geometry: x then y, signed positions
	typedef struct packed {
		logic signed [31:0] x;
		logic signed [31:0] y;
	} point_t;

	// every stateful bit of the block
	typedef struct packed {
		ctl_state_t  st;
		logic [15:0] cnt;
		logic [15:0] period;
		logic        act;
		logic        stretch;
		logic        plus_dir;
		logic        interp;
		logic        arc;
		logic        slow_pend;
		logic        slow_end;
		logic        fast_end;
		logic        limit_end;
		logic        error;
		logic        arc_pause;
		logic        pulse_n;
	} state_t;
endpackage

// file: hw/pulse_stop_ctrl.sv
// per-axis pulse drive: arc validity checks, constant linear speed stretching, four stop paths
// assumes all machine inputs already synchronous to core_clk_i and active high
//
// Summary of operation
// - center arc: start or destination on center errors
// - pass arc: coinciding points error, no run
// - radius outside 2..759250124 errors, no run
// - off-arc destination pauses on short-axis match, long-axis match inside the circle
// - short axis has smaller centered coordinate
// - simultaneous pulses stretch next period 1.414 by lengthening its high phase
// - external pulse output blocks every stop
// - slow stop in standby/drive decelerates, sets flag
// - slow stop from command, input, selects, comparators
// - standby slow stop waits; early one ends drive
// - no slow stop in post-interpolation standby
// - immediate stop while busy, except settle standby, ends, sets flag
// - immediate stop from command, halts, selects, comparators
// - immediate stop finishes current active pulse width
// - data-setting command survives; fast flag unchanged
// - limit slow stop: direction limits, soft limit
// - interpolation: early slow limit ends any direction
// - slow limit own direction; sets slow, limit
// - fast limit own direction; sets fast, limit
// - fast limit stays live in post-interpolation standby
// - fast limit finishes current active pulse width
// - slow limit standby rules mirror slow stop
// - stop on either paired axis ends drive
`timescale 1ns/1ps
module pulse_stop_ctrl #(
	parameter int unsigned ACT_CYC = pulse_stop_pkg::PULSE_ACT_CYC  // active pulse width in cycles
) (
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    start_i,                   // drive command: enter standby
	input  wire logic [1:0]              kind_i,                    // drive_kind_t
	input  wire logic                    plus_dir_i,                // travel toward + when high
	input  wire logic                    release_i,                 // standby over, begin pulses
	input  wire logic                    done_i,                    // target reached
	input  wire logic                    settle_need_i,             // wait for servo settle after pulses
	input  wire logic                    servo_settle_input_i,      // servo reports in position
	input  wire logic                    external_pulse_out_bit_i,  // external pulse source running
	input  wire logic                    data_cmd_busy_i,           // data-setting command executing
	input  wire logic                    slow_cmd_i,                // slow stop command pulse
	input  wire logic                    fast_cmd_i,                // fast stop command pulse
	input  wire logic                    decel_stop_input_i,
	input  wire logic                    stop_select_input_0_i,
	input  wire logic                    stop_select_input_1_i,
	input  wire logic                    driver_alarm_input_i,
	input  wire logic [2:0]              select_fast_i,             // per select/alarm input: 1 immediate
	input  wire logic                    emergency_halt_input_1_i,
	input  wire logic                    emergency_halt_input_2_i,
	input  wire logic                    cmp_slow_i,                // comparator set to slow stop
	input  wire logic                    cmp_fast_i,                // comparator set to immediate stop
	input  wire logic                    plus_travel_limit_i,
	input  wire logic                    minus_travel_limit_i,
	input  wire logic                    limit_fast_i,              // limits act as immediate stop
	input  wire logic                    soft_limit_i,              // soft limit position reached
	input  wire logic                    partner_slow_i,            // paired axis slow stop
	input  wire logic                    partner_fast_i,            // paired axis immediate stop
	input  wire logic [15:0]             period_i,                  // pulse period in cycles
	input  wire logic [15:0]             end_period_i,              // period at end speed
	input  wire logic                    lin_const_i,               // constant linear speed on
	input  wire logic                    both_pulse_i,              // paired axis pulses with this one
	input  wire logic                    status_clear_i,            // clear end and error flags
	input  wire pulse_stop_pkg::point_t  cur_i,                     // current position
	input  wire pulse_stop_pkg::point_t  cen_i,                     // arc center
	input  wire pulse_stop_pkg::point_t  pas_i,                     // arc passing point
	input  wire pulse_stop_pkg::point_t  dst_i,                     // destination
	input  wire pulse_stop_pkg::point_t  pos_i,                     // interpolation coordinate
	output pulse_stop_pkg::status_t      primary_status_port_o,
	output logic                         pulse_n_o,                 // drive pulse, active low
	output logic                         short_axis_y_o,            // short axis is y
	output logic                         arc_pause_o,               // pause at off-arc destination
	output logic                         slow_req_o,                // slow stop raised on this axis
	output logic                         fast_req_o                 // immediate stop raised on this axis
);
	pulse_stop_pkg::state_t q;        // registered state
	pulse_stop_pkg::state_t next_q;   // next state

	// squared distance between two points
	function automatic logic [65:0] dist2(input pulse_stop_pkg::point_t a, input pulse_stop_pkg::point_t b);
		logic signed [32:0] dx;
		logic signed [32:0] dy;
		dx = 33'(a.x) - 33'(b.x);
		dy = 33'(a.y) - 33'(b.y);
		dist2 = 66'(dx * dx) + 66'(dy * dy);
	endfunction

	// magnitude of a signed coordinate
	function automatic logic [31:0] mag(input logic signed [31:0] v);
		mag = v[31] ? 32'(-v) : v;
	endfunction

	// arc geometry
	logic [65:0] r2;          // radius squared, start to center
	logic [65:0] d2;          // destination to center squared
	logic        arc_err;     // arc cannot be run
	logic        on_circle;   // destination lies on the arc
	logic        same_pt;     // coincident point rule hit
	logic        rad_bad;     // radius out of span
	logic signed [31:0] ddx;  // destination relative to center
	logic signed [31:0] ddy;
	logic        dst_short_y; // destination short axis is y
	logic        quad_ok;     // position in destination quadrant
	logic        match;       // pause coordinate met

	always_comb begin
		r2 = dist2(cur_i, cen_i);
		d2 = dist2(dst_i, cen_i);
		rad_bad = (r2 < 66'(pulse_stop_pkg::RAD_MIN) * 66'(pulse_stop_pkg::RAD_MIN)) ||
			(r2 > 66'(pulse_stop_pkg::RAD_MAX) * 66'(pulse_stop_pkg::RAD_MAX));
		if (kind_i == pulse_stop_pkg::KIND_ARC_CENTER) begin
			same_pt = (cur_i == cen_i) || (cen_i == dst_i);
		end else begin
			same_pt = (cur_i == pas_i) || (pas_i == dst_i) || (cur_i == dst_i);
		end
		arc_err = kind_i[1] && (same_pt || rad_bad);
		on_circle = (d2 == r2);
		ddx = dst_i.x - cen_i.x;
		ddy = dst_i.y - cen_i.y;
		dst_short_y = mag(ddy) < mag(ddx);
		quad_ok = (pos_i.x[31] == ddx[31]) && (pos_i.y[31] == ddy[31]);
		// inside the circle the long axis is matched instead
		if (dst_short_y ^ (d2 < r2)) begin
			match = quad_ok && (pos_i.y == ddy);
		end else begin
			match = quad_ok && (pos_i.x == ddx);
		end
	end

	// short axis of the running interpolation coordinate
	assign short_axis_y_o = mag(pos_i.y) < mag(pos_i.x);

	// stop request gathering
	logic limit_hit;    // limit in travel direction
	logic limit_any;    // either limit, direction ignored
	logic slow_src;     // any slow stop source
	logic fast_src;     // any immediate stop source
	logic lim_slow;     // limit slow stop source
	logic lim_fast;     // limit immediate stop source

	always_comb begin
		limit_hit = (q.st == pulse_stop_pkg::ST_IDLE) ? (plus_dir_i ? plus_travel_limit_i : minus_travel_limit_i)
			: (q.plus_dir ? plus_travel_limit_i : minus_travel_limit_i);
		limit_any = plus_travel_limit_i || minus_travel_limit_i;
		slow_src = slow_cmd_i || decel_stop_input_i || cmp_slow_i ||
			(stop_select_input_0_i && !select_fast_i[0]) ||
			(stop_select_input_1_i && !select_fast_i[1]) ||
			(driver_alarm_input_i && !select_fast_i[2]);
		fast_src = fast_cmd_i || emergency_halt_input_1_i || emergency_halt_input_2_i || cmp_fast_i ||
			(stop_select_input_0_i && select_fast_i[0]) ||
			(stop_select_input_1_i && select_fast_i[1]) ||
			(driver_alarm_input_i && select_fast_i[2]);
		lim_slow = (limit_hit && !limit_fast_i) || soft_limit_i;
		lim_fast = limit_hit && limit_fast_i;
	end

	assign slow_req_o = slow_src || lim_slow;
	assign fast_req_o = fast_src || lim_fast;

	// stretched period for the phase after a simultaneous pulse
	logic [23:0] wide;    // period times 181
	logic [15:0] hi_len;  // high phase length

	always_comb begin
		wide = 24'(q.period) * 24'(pulse_stop_pkg::STRETCH_MUL);
		hi_len = q.period - 16'(ACT_CYC);
		if (q.stretch) begin
			hi_len = 16'(wide >> pulse_stop_pkg::STRETCH_SHIFT) - 16'(ACT_CYC);
		end
	end

	// next state
	logic blocked;   // stops disabled
	logic slow_now;  // slow stop to act this cycle
	logic fast_now;  // immediate stop to act this cycle
	logic lim_fsl;   // limit slow flavour for flags
	logic pulse_end; // end of one whole period

	always_comb begin
		next_q = q;
		blocked = external_pulse_out_bit_i;
		lim_fsl = lim_slow && !soft_limit_i;
		slow_now = !blocked && (slow_src || lim_slow || (q.interp && partner_slow_i) || q.slow_pend);
		fast_now = !blocked && !data_cmd_busy_i && (fast_src || lim_fast || (q.interp && partner_fast_i));
		pulse_end = !q.act && (q.cnt <= 16'h0001);
		// sticky flags fall only on clear
		if (status_clear_i) begin
			next_q.slow_end = 1'b0;
			next_q.fast_end = 1'b0;
			next_q.limit_end = 1'b0;
			next_q.error = 1'b0;
			next_q.arc_pause = 1'b0;
		end
		// pulse phase timer
		if (q.st != pulse_stop_pkg::ST_IDLE && q.st != pulse_stop_pkg::ST_STANDBY_WAIT_BIT) begin
			if (q.cnt > 16'h0001) begin
				next_q.cnt = q.cnt - 16'h0001;
			end else if (q.act) begin
				next_q.act = 1'b0;
				next_q.pulse_n = 1'b1;
				next_q.cnt = hi_len;
				next_q.stretch = 1'b0;
			end else begin
				next_q.act = 1'b1;
				next_q.pulse_n = 1'b0;
				next_q.cnt = 16'(ACT_CYC);
				next_q.stretch = lin_const_i && both_pulse_i;
			end
		end
		unique case (q.st)
			// waiting for a drive command
			pulse_stop_pkg::ST_IDLE: begin
				next_q.pulse_n = 1'b1;
				next_q.act = 1'b0;
				if (start_i && arc_err) begin
					next_q.error = 1'b1;
				end else if (start_i && !blocked && (slow_src || lim_slow ||
					(kind_i != pulse_stop_pkg::KIND_SINGLE && !limit_fast_i && limit_any))) begin
					next_q.slow_end = 1'b1;
					next_q.limit_end = next_q.limit_end || (!slow_src && (lim_fsl || kind_i != pulse_stop_pkg::KIND_SINGLE));
				end else if (start_i) begin
					next_q.st = pulse_stop_pkg::ST_STANDBY_WAIT_BIT;
					next_q.plus_dir = plus_dir_i;
					next_q.interp = kind_i != pulse_stop_pkg::KIND_SINGLE;
					next_q.arc = kind_i[1];
					next_q.period = period_i;
					next_q.slow_pend = 1'b0;
					next_q.stretch = 1'b0;
				end
			end
			// standby before pulses
			pulse_stop_pkg::ST_STANDBY_WAIT_BIT: begin
				if (fast_now) begin
					next_q.st = pulse_stop_pkg::ST_IDLE;
					next_q.fast_end = 1'b1;
					next_q.limit_end = next_q.limit_end || lim_fast;
				end else begin
					if (!blocked && (slow_src || lim_slow)) begin
						next_q.slow_pend = 1'b1;
						next_q.limit_end = next_q.limit_end || lim_fsl;
					end
					if (release_i) begin
						next_q.st = pulse_stop_pkg::ST_DRIVE;
						next_q.act = 1'b1;
						next_q.pulse_n = 1'b0;
						next_q.cnt = 16'(ACT_CYC);
					end
				end
			end
			// pulses running at speed or slowing down
			pulse_stop_pkg::ST_DRIVE, pulse_stop_pkg::ST_DECEL: begin
				if (fast_now) begin
					next_q.fast_end = 1'b1;
					next_q.limit_end = next_q.limit_end || lim_fast;
					next_q.st = q.act ? pulse_stop_pkg::ST_FINISH : pulse_stop_pkg::ST_IDLE;
					next_q.pulse_n = q.act ? next_q.pulse_n : 1'b1;
				end else if (q.arc && !on_circle && match && q.st == pulse_stop_pkg::ST_DRIVE) begin
					next_q.arc_pause = 1'b1;
					next_q.st = q.act ? pulse_stop_pkg::ST_FINISH : pulse_stop_pkg::ST_IDLE;
					next_q.pulse_n = q.act ? next_q.pulse_n : 1'b1;
				end else if (slow_now && q.st == pulse_stop_pkg::ST_DRIVE) begin
					next_q.st = pulse_stop_pkg::ST_DECEL;
					next_q.slow_end = 1'b1;
					next_q.limit_end = next_q.limit_end || lim_fsl;
				end else if (q.st == pulse_stop_pkg::ST_DECEL && pulse_end) begin
					next_q.period = q.period + pulse_stop_pkg::DECEL_STEP;
					if (q.period >= end_period_i) begin
						next_q.st = pulse_stop_pkg::ST_IDLE;  // end speed reached
						next_q.pulse_n = 1'b1;
						next_q.act = 1'b0;
					end
				end else if (done_i && q.st == pulse_stop_pkg::ST_DRIVE) begin
					next_q.st = (q.interp && settle_need_i) ? pulse_stop_pkg::ST_SETTLE : pulse_stop_pkg::ST_FINISH;
				end
			end
			// finish the active width then stop
			pulse_stop_pkg::ST_FINISH: begin
				if (!q.act || q.cnt <= 16'h0001) begin
					next_q.st = pulse_stop_pkg::ST_IDLE;
					next_q.pulse_n = 1'b1;
					next_q.act = 1'b0;
				end
			end
			// post-interpolation standby: only limit fast stop acts
			pulse_stop_pkg::ST_SETTLE: begin
				if (!q.act) begin
					next_q.pulse_n = 1'b1;
					next_q.act = 1'b0;
				end
				if (!blocked && lim_fast) begin
					next_q.fast_end = 1'b1;
					next_q.limit_end = 1'b1;
					next_q.st = q.act ? pulse_stop_pkg::ST_FINISH : pulse_stop_pkg::ST_IDLE;
				end else if (servo_settle_input_i) begin
					next_q.st = q.act ? pulse_stop_pkg::ST_FINISH : pulse_stop_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{st: pulse_stop_pkg::ST_IDLE, cnt: 16'h0000, period: pulse_stop_pkg::PERIOD_RST,
				pulse_n: 1'b1, default: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	// status and outputs
	always_comb begin
		primary_status_port_o.busy = q.st != pulse_stop_pkg::ST_IDLE;
		primary_status_port_o.drive = q.st inside {pulse_stop_pkg::ST_DRIVE, pulse_stop_pkg::ST_DECEL};
		primary_status_port_o.standby_wait_bit = q.st inside {pulse_stop_pkg::ST_STANDBY_WAIT_BIT, pulse_stop_pkg::ST_SETTLE};
		primary_status_port_o.external_pulse_out_bit = external_pulse_out_bit_i;
		primary_status_port_o.slow_end_flag = q.slow_end;
		primary_status_port_o.fast_end_flag = q.fast_end;
		primary_status_port_o.limit_end_flag = q.limit_end;
		primary_status_port_o.error = q.error;
	end

	assign pulse_n_o = q.pulse_n;
	assign arc_pause_o = q.arc_pause;

	// checks
	AST_ARC_ERR: assert property (@(posedge core_clk_i) disable iff (rst_i)
		q.st == pulse_stop_pkg::ST_IDLE && start_i && arc_err |=> q.error && q.st == pulse_stop_pkg::ST_IDLE)
		else $error("arc error not flagged or drive started");
	AST_EXT_BLOCK: assert property (@(posedge core_clk_i) disable iff (rst_i)
		external_pulse_out_bit_i && q.st == pulse_stop_pkg::ST_DRIVE && !done_i |=> q.st != pulse_stop_pkg::ST_DECEL)
		else $error("stop honoured during external pulse output");
	AST_SLOW_FLAG: assert property (@(posedge core_clk_i) disable iff (rst_i)
		q.st == pulse_stop_pkg::ST_DRIVE && slow_cmd_i && !fast_now && !blocked && !(q.arc && match)
		|=> q.slow_end && q.st == pulse_stop_pkg::ST_DECEL)
		else $error("slow stop not taken");
	AST_FAST_FLAG: assert property (@(posedge core_clk_i) disable iff (rst_i)
		primary_status_port_o.drive && fast_cmd_i && !blocked && !data_cmd_busy_i
		|=> q.fast_end ##1 !primary_status_port_o.drive)
		else $error("fast stop not taken");
	AST_ACT_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
		primary_status_port_o.drive && fast_now && q.act && q.cnt > 16'h0001 |=> !pulse_n_o)
		else $error("active pulse cut short");
	AST_DATA_CMD: assert property (@(posedge core_clk_i) disable iff (rst_i)
		data_cmd_busy_i && !q.fast_end && !status_clear_i && !lim_fast && !(q.interp && partner_fast_i)
		&& q.st != pulse_stop_pkg::ST_SETTLE |=> !q.fast_end)
		else $error("fast flag set during data command");
	AST_LIMIT_DIR: assert property (@(posedge core_clk_i) disable iff (rst_i)
		q.st == pulse_stop_pkg::ST_DRIVE && q.plus_dir && !plus_travel_limit_i && !soft_limit_i
		&& !q.limit_end && !status_clear_i |=> !q.limit_end)
		else $error("limit acted against its direction");
	AST_SETTLE_SLOW: assert property (@(posedge core_clk_i) disable iff (rst_i)
		q.st == pulse_stop_pkg::ST_SETTLE && !q.slow_end && !status_clear_i |=> !q.slow_end)
		else $error("slow stop acted in settle standby");
	AST_STICKY: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!status_clear_i |=> q.slow_end >= $past(q.slow_end) && q.fast_end >= $past(q.fast_end)
		&& q.limit_end >= $past(q.limit_end) && q.error >= $past(q.error))
		else $error("end or error flag dropped without clear");

	COV_SLOW: cover property (@(posedge core_clk_i) disable iff (rst_i)
		q.st == pulse_stop_pkg::ST_DECEL ##[1:1000] q.st == pulse_stop_pkg::ST_IDLE);
	COV_FINISH: cover property (@(posedge core_clk_i) disable iff (rst_i) q.st == pulse_stop_pkg::ST_FINISH);
	COV_SETTLE_LIM: cover property (@(posedge core_clk_i) disable iff (rst_i)
		q.st == pulse_stop_pkg::ST_SETTLE && lim_fast);
	COV_STRETCH: cover property (@(posedge core_clk_i) disable iff (rst_i) q.stretch && !q.act);
endmodule

// file: verif/machine_side_model.sv
// machine side model: travel limit sensors and servo in-position report
// assumes bench requests are synchronous to core_clk_i
`timescale 1ns/1ps
module machine_side_model #(
	parameter int unsigned SETTLE_CYC = 8  // servo settle delay, a plain value of our own
) (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] lim_req_i,    // bench asks for {plus, minus} sensor hit
	input  wire logic       settle_go_i,  // pulses stopped, servo starts settling
	output logic            plus_travel_limit_o,
	output logic            minus_travel_limit_o,
	output logic            servo_settle_input_o
);
	logic [15:0] wait_cnt;  // cycles spent settling
	// sensors lag by one cycle; servo reports only after its delay, never early
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			{plus_travel_limit_o, minus_travel_limit_o, servo_settle_input_o} <= 3'h0;
			wait_cnt <= 16'h0000;
		end else begin
			{plus_travel_limit_o, minus_travel_limit_o} <= lim_req_i;
			wait_cnt <= settle_go_i ? wait_cnt + 16'h0001 : 16'h0000;
			servo_settle_input_o <= settle_go_i && (wait_cnt >= 16'(SETTLE_CYC));
		end
	end
endmodule

// file: verif/pulse_drive_stop_and_arc_check_tb.sv
// bench for the per-axis stop and arc check block: arcs, stop sources, limits, settle standby
// assumes the machine side model drives limit and servo inputs
`timescale 1ns/1ps
module pulse_drive_stop_and_arc_check_tb;
	localparam int unsigned ACT = 5;  // active pulse width in cycles
	logic core_clk_i, rst_i, start_i, plus_dir_i, release_i, done_i, settle_need_i, servo_settle_input_i;
	logic external_pulse_out_bit_i, data_cmd_busy_i, slow_cmd_i, fast_cmd_i, decel_stop_input_i, soft_limit_i;
	logic stop_select_input_0_i, stop_select_input_1_i, driver_alarm_input_i, emergency_halt_input_1_i;
	logic emergency_halt_input_2_i, cmp_slow_i, cmp_fast_i, plus_travel_limit_i, minus_travel_limit_i;
	logic limit_fast_i, partner_slow_i, partner_fast_i, lin_const_i, both_pulse_i, status_clear_i, settle_go;
	logic pulse_n_o, short_axis_y_o, arc_pause_o, slow_req_o, fast_req_o;
	logic [1:0]              kind_i, lim_req;
	logic [2:0]              select_fast_i;
	logic [15:0]             period_i, end_period_i;
	pulse_stop_pkg::point_t  cur_i, cen_i, pas_i, dst_i, pos_i;
	pulse_stop_pkg::status_t primary_status_port_o, st;
	int                      n_errors = 0, samples_checked = 0;
	assign st = primary_status_port_o;
	machine_side_model partner (.core_clk_i(core_clk_i), .rst_i(rst_i), .lim_req_i(lim_req),
		.settle_go_i(settle_go), .plus_travel_limit_o(plus_travel_limit_i),
		.minus_travel_limit_o(minus_travel_limit_i), .servo_settle_input_o(servo_settle_input_i));
	pulse_stop_ctrl #(.ACT_CYC(ACT)) dut (.*);
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// raise or drop one stop source: 0..7 immediate, 8..15 slow
	task automatic src(input int i, input logic v);
		logic [15:0] h;
		h = v ? 16'h0001 << i : 16'h0000;
		@(posedge core_clk_i);
		select_fast_i <= (i < 8) ? 3'h7 : 3'h0;
		{partner_fast_i, cmp_fast_i, emergency_halt_input_2_i, emergency_halt_input_1_i, fast_cmd_i} <= h[4:0];
		{stop_select_input_0_i, stop_select_input_1_i, driver_alarm_input_i} <= h[7:5] | h[14:12];
		{partner_slow_i, cmp_slow_i, decel_stop_input_i, slow_cmd_i, soft_limit_i} <= {h[11:8], h[15]};
		#1;
	endtask
	task automatic lim(input logic [1:0] v, input logic f);
		@(posedge core_clk_i);
		lim_req <= v;
		limit_fast_i <= f;
		tick(2);
	endtask
	task automatic launch(input logic [1:0] k, input logic d);
		@(posedge core_clk_i);
		{start_i, kind_i, plus_dir_i} <= {1'b1, k, d};
		@(posedge core_clk_i);
		start_i <= 1'b0;
		#1;
	endtask
	task automatic go;
		@(posedge core_clk_i);
		release_i <= 1'b1;
		@(posedge core_clk_i);
		release_i <= 1'b0;
		#1;
	endtask
	task automatic wait_idle;
		for (int k = 0; k < 400 && st.busy !== 1'b0; k++) tick(1);
		chk("busy", 32'h0, st.busy);
	endtask
	task automatic clear;
		@(posedge core_clk_i);
		status_clear_i <= 1'b1;
		@(posedge core_clk_i);
		status_clear_i <= 1'b0;
		#1;
		chk("flags", 32'h0, {st.slow_end_flag, st.fast_end_flag, st.limit_end_flag, st.error});
	endtask
	// arc start with a given geometry; bad ones must flag and not run
	task automatic arc(input logic [1:0] k, input int cx, px, py, ex, input logic err);
		clear;
		@(posedge core_clk_i);
		{cen_i, pas_i, dst_i} <= {cx, 32'h0, px, py, ex, 32'h0};
		launch(k, 1'b1);
		tick(3);
		chk("arc error", {!err, err}, {st.standby_wait_bit, st.error});
		src(0, 1'b1);
		wait_idle;
		src(0, 1'b0);
	endtask
	// each source ends an interpolated drive with its own flag
	task automatic t_stop(input int i);
		clear;
		launch(2'h1, 1'b1);
		go;
		src(i, 1'b1);
		chk("stop requests", (i == 4 || i == 11) ? 32'h0 : (i < 8) ? 32'h2 : 32'h1, {fast_req_o, slow_req_o});
		wait_idle;
		src(i, 1'b0);
		chk("stop flags", (i < 8) ? 32'h1 : 32'h2, {st.slow_end_flag, st.fast_end_flag});
	endtask
	// off-arc destination inside the circle: pause where the long axis matches
	task automatic t_pause;
		clear;
		launch(2'h2, 1'b1);
		go;
		wait_idle;
		chk("arc pause", 32'h2, {arc_pause_o, st.fast_end_flag});
	endtask
	// simultaneous pulses: 15 plain high cycles, then 28-5 stretched ones
	task automatic t_stretch;
		int n;
		n = 0;
		clear;
		{lin_const_i, both_pulse_i} <= 2'h3;
		launch(2'h1, 1'b1);
		go;
		for (int k = 0; k < 48; k++) begin
			if (pulse_n_o === 1'b1) n++;
			tick(1);
		end
		chk("high cycles", 32'd38, n);
		{lin_const_i, both_pulse_i} <= 2'h0;
		src(0, 1'b1);
		wait_idle;
		src(0, 1'b0);
	endtask
	// immediate stop inside the active phase keeps the full width
	task automatic t_width;
		int n;
		n = 0;
		clear;
		launch(2'h0, 1'b1);
		go;
		for (int k = 0; k < 10; k++) begin
			if (pulse_n_o === 1'b0) n++;
			src(0, 1'b1);
		end
		src(0, 1'b0);
		wait_idle;
		chk("active width", ACT, n);
	endtask
	task automatic t_block;
		for (int m = 0; m < 2; m++) begin
			clear;
			{external_pulse_out_bit_i, data_cmd_busy_i} <= (m == 0) ? 2'h2 : 2'h1;
			launch(2'h0, 1'b1);
			go;
			src(0, 1'b1);
			tick(4);
			chk("blocked stop", 32'h2, {st.busy, st.fast_end_flag});
			{external_pulse_out_bit_i, data_cmd_busy_i} <= 2'h0;
			wait_idle;
			src(0, 1'b0);
		end
	endtask
	task automatic t_limit;
		for (int m = 0; m < 2; m++) begin
			clear;
			lim(2'h1, m[0]);
			launch(2'h0, 1'b1);
			go;
			tick(6);
			chk("wrong-way limit", 32'h1, st.busy);
			lim(2'h2, m[0]);
			wait_idle;
			chk("limit flags", m ? 32'h3 : 32'h5, {st.slow_end_flag, st.fast_end_flag, st.limit_end_flag});
			lim(2'h0, 1'b0);
		end
	endtask
	task automatic t_settle;
		for (int m = 0; m < 2; m++) begin
			clear;
			settle_need_i <= 1'b1;
			launch(2'h1, 1'b1);
			go;
			{done_i, settle_go} <= 2'h2;
			tick(1);
			done_i <= 1'b0;
			for (int k = 0; k < 60 && st.drive !== 1'b0; k++) tick(1);
			src(8, 1'b1);
			tick(4);
			chk("settle slow", 32'h2, {st.standby_wait_bit, st.slow_end_flag});
			src(8, 1'b0);
			if (m) lim(2'h2, 1'b1);
			settle_go <= !m;
			wait_idle;
			chk("settle limit", m ? 32'h3 : 32'h0, {st.fast_end_flag, st.limit_end_flag});
			{settle_need_i, settle_go} <= 2'h0;
			lim(2'h0, 1'b0);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#1_000_000;
		n_errors++;
		final_report;
	end
	initial begin
		{start_i, plus_dir_i, release_i, done_i, settle_need_i, external_pulse_out_bit_i, data_cmd_busy_i} = '0;
		{status_clear_i, settle_go, kind_i, lim_req, limit_fast_i, lin_const_i, both_pulse_i} = '0;
		{cur_i, cen_i, pas_i, dst_i, period_i, end_period_i} = {256'h0, 16'h0014, 16'h0016};
		pos_i = '{32'sh0000_000A, 32'sh0000_0003};
		rst_i = 1'b1;
		src(0, 1'b0);
		repeat (12) @(posedge core_clk_i);
		rst_i <= 1'b0;
		tick(1);
		chk("short axis", 32'h1, short_axis_y_o);
		arc(2'h2, 0, 9, 9, 9, 1'b1);
		arc(2'h2, 100, 9, 9, 100, 1'b1);
		arc(2'h2, 1, 9, 9, 2, 1'b1);
		arc(2'h2, 2, 9, 9, 4, 1'b0);
		arc(2'h2, 759250124, 9, 9, 1518500248, 1'b0);
		arc(2'h2, 759250125, 9, 9, 1518500250, 1'b1);
		arc(2'h3, 100, 50, 0, 50, 1'b1);
		arc(2'h2, 20, 9, 9, 30, 1'b0);
		t_pause;
		t_stretch;
		for (int i = 0; i < 16; i++) t_stop(i);
		t_width;
		t_block;
		t_limit;
		t_settle;
		clear;
		src(8, 1'b1);
		launch(2'h1, 1'b1);
		chk("early slow", 32'h2, {st.slow_end_flag, st.busy});
		src(8, 1'b0);
		final_report;
	end
endmodule
